/* File: hw/tcr_pkg.sv */
// Package with register map, field positions, reset values and carrier types of the timer.
package tcr_pkg;
  // Register byte addresses; printed offsets are multiples of four only in part, so index*4.
  localparam logic [7:0] CTRL_IDX = 8'hC8;
  localparam logic [7:0] MODE_IDX = 8'hC9;
  localparam logic [7:0] RCL_IDX = 8'hCA;
  localparam logic [7:0] RCH_IDX = 8'hCB;
  localparam logic [7:0] CNTL_IDX = 8'hCC;
  localparam logic [7:0] CNTH_IDX = 8'hCD;
  localparam logic [7:0] DIR_IDX = 8'hCE;
  localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
  localparam logic [9:0] MODE_ADDR = {MODE_IDX, 2'h0};
  localparam logic [9:0] RCL_ADDR = {RCL_IDX, 2'h0};
  localparam logic [9:0] RCH_ADDR = {RCH_IDX, 2'h0};
  localparam logic [9:0] CNTL_ADDR = {CNTL_IDX, 2'h0};
  localparam logic [9:0] CNTH_ADDR = {CNTH_IDX, 2'h0};
  localparam logic [9:0] DIR_ADDR = {DIR_IDX, 2'h0};
  // Control register field positions.
  localparam int CT_OVF = 7;
  localparam int CT_EXF = 6;
  localparam int CT_RCLK = 5;
  localparam int CT_TCLK = 4;
  localparam int CT_EXEN = 3;
  localparam int CT_RUN = 2;
  localparam int CT_CTS = 1;
  localparam int CT_CPRL = 0;
  // Mode register field positions and writable mask.
  localparam int MD_CLR = 3;
  localparam int MD_OE = 1;
  localparam int MD_DOWN_COUNT_ENABLE = 0;
  localparam logic [7:0] MODE_MASK = 8'hFB;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Baud-generator mode advances every this many clocks; timebase prescales.
  localparam int BAUD_DIV = 2;
  localparam int SLOW_DIV = 12;
  localparam int FAST_DIV = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // Bus request captured at the address phase.
  typedef struct packed {
    logic act;
    logic wr;
    logic [9:0] addr;
  } tcr_req_t;

  // Whole state of the timer.
  typedef struct packed {
    tcr_req_t req;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [15:0] rcap;
    logic [15:0] cnt;
    logic [3:0] pre;
    logic cnt_pin_q;
    logic cap_pin_q;
    logic clk_out;
    logic baud_tick;
    logic irq;
  } tcr_state_t;
endpackage : tcr_pkg

/* File: hw/tcr_timer.sv */
// Third timer: capture, auto-reload, up/down, baud generation and clock out over AHB-Lite.
//
// Notes on behaviour
// - Overflow flag sets on counter overflow, or count equals reload in down mode.
// - Hardware sets overflow flag only with both baud selects zero; software writes it.
// - External flag sets on capture-pin falling edge or overflow per mode bits.
// - Software setting external flag or pin edge raises timer interrupt if enabled.
// - Receive baud select one uses this overflow and forces baud mode.
// - Transmit baud select one uses this overflow and forces baud mode.
// - Capture pin edges ignored unless enabled and not in baud mode.
// - Run control clear halts counter; a pin-triggered capture clear or reload still changes the count bytes.
// - Baud mode advances counter once every two clocks.
// - Outside baud mode, select zero counts timebase ticks; one counts count-pin falling edges.
// - Either baud select forces auto-reload after every overflow.
// - Reload mode reloads on up-count overflow and, with down-count enable clear, on enabled capture-pin falling edge.
// - Capture mode copies counter into capture pair on enabled pin edge.
// - Capture auto-clear resets counter when copied into capture pair.
// - Clock out drives only while clock-out enable is set.
// - Down-count enable with capture pin picks count direction in reload mode.
// - Low capture register takes low count or supplies low reload byte.
// - High capture register takes high count or supplies high reload byte.
// - Count high byte is its own register paired with the low byte.
`timescale 1ns/1ps
module tcr_timer (
  input wire logic clk_sys_in, // 25 MHz clock.
  input wire logic rstn_in, // Asynchronous reset, active low.
  input wire logic hsel_in, // Slave select.
  input wire logic [31:0] haddr_in, // Byte address.
  input wire logic [1:0] htrans_in, // Transfer type.
  input wire logic hwrite_in, // Write when high.
  input wire logic [2:0] hsize_in, // Transfer size.
  input wire logic [31:0] hwdata_in, // Write data.
  input wire logic hready_in, // Bus ready.
  input wire logic timebase_select_in, // Timebase: 1 divides by 4, 0 by 12.
  input wire logic count_input_pin_in, // External count pin.
  input wire logic ext_capture_pin_in, // External capture/reload pin.
  input wire logic int_enable_in, // Timer interrupt enable from the core.
  output logic [31:0] hrdata_out, // Read data.
  output logic hreadyout_out, // Always ready.
  output logic hresp_out, // Always OKAY.
  output logic clk_out_out, // Clock-out pin level.
  output logic clk_out_oe_out, // Clock-out pin enable.
  output logic baud_tick_out, // One-cycle overflow pulse used as baud clock.
  output logic rx_baud_sel_out, // Receive uses this timer.
  output logic tx_baud_sel_out, // Transmit uses this timer.
  output logic irq_out // Timer interrupt level.
);

  tcr_pkg::tcr_state_t st_ff;
  tcr_pkg::tcr_state_t nxt_st;
  logic oe_ff;

  // Reads the register selected by a byte address.
  function automatic logic [7:0] rd_reg(input tcr_pkg::tcr_state_t s, input logic [9:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      tcr_pkg::CTRL_ADDR: r = s.ctrl;
      tcr_pkg::MODE_ADDR: r = s.mode;
      tcr_pkg::RCL_ADDR: r = s.rcap[7:0];
      tcr_pkg::RCH_ADDR: r = s.rcap[15:8];
      tcr_pkg::CNTL_ADDR: r = s.cnt[7:0];
      tcr_pkg::CNTH_ADDR: r = s.cnt[15:8];
      tcr_pkg::DIR_ADDR: r = {7'h00, s.cap_pin_q};
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rd_reg

  // Next-state logic: bus slave, edge detect, prescaler and counter.
  always_comb
  begin
    logic [7:0] c;
    logic [7:0] wd;
    logic baud;
    logic cnt_fall;
    logic cap_fall;
    logic tick;
    logic dn;
    logic ovf;
    logic pin_ev;
    logic [3:0] lim;
    c = st_ff.ctrl;
    wd = hwdata_in[7:0];
    baud = 1'b0;
    cnt_fall = 1'b0;
    cap_fall = 1'b0;
    tick = 1'b0;
    dn = 1'b0;
    ovf = 1'b0;
    pin_ev = 1'b0;
    lim = 4'h0;
    nxt_st = st_ff;
    nxt_st.baud_tick = 1'b0;
    // Address phase capture; only word transfers are issued by the master.
    nxt_st.req.act = hsel_in && hready_in && (htrans_in == tcr_pkg::HTRANS_NONSEQ);
    nxt_st.req.wr = hwrite_in;
    nxt_st.req.addr = haddr_in[9:0];
    // Falling edges from consecutive samples of the pins.
    nxt_st.cnt_pin_q = count_input_pin_in;
    nxt_st.cap_pin_q = ext_capture_pin_in;
    cnt_fall = st_ff.cnt_pin_q && !count_input_pin_in;
    cap_fall = st_ff.cap_pin_q && !ext_capture_pin_in;
    baud = c[tcr_pkg::CT_RCLK] || c[tcr_pkg::CT_TCLK];
    pin_ev = cap_fall && c[tcr_pkg::CT_EXEN] && !baud;
    // Timebase prescaler; baud mode forces a two-clock tick.
    if (baud)
    begin
      lim = 4'(tcr_pkg::BAUD_DIV - 1);
    end
    else if (timebase_select_in)
    begin
      lim = 4'(tcr_pkg::FAST_DIV - 1);
    end
    else
    begin
      lim = 4'(tcr_pkg::SLOW_DIV - 1);
    end
    if (c[tcr_pkg::CT_RUN])
    begin
      nxt_st.pre = (st_ff.pre >= lim) ? 4'h0 : st_ff.pre + 4'h1;
      if (baud || !c[tcr_pkg::CT_CTS])
      begin
        tick = (st_ff.pre >= lim);
      end
      else
      begin
        tick = cnt_fall;
      end
    end
    // Down count only in plain reload mode with enable; pin low means down.
    dn = !baud && !c[tcr_pkg::CT_CPRL] && st_ff.mode[tcr_pkg::MD_DOWN_COUNT_ENABLE]
      && !ext_capture_pin_in;
    if (tick)
    begin
      if (dn)
      begin
        if (st_ff.cnt == st_ff.rcap)
        begin
          ovf = 1'b1;
          nxt_st.cnt = 16'hFFFF;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt - 16'h0001;
        end
      end
      else if (st_ff.cnt == 16'hFFFF)
      begin
        ovf = 1'b1;
        if (baud || !c[tcr_pkg::CT_CPRL])
        begin
          nxt_st.cnt = st_ff.rcap;
        end
        else
        begin
          nxt_st.cnt = 16'h0000;
        end
      end
      else
      begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
    end
    // Pin-triggered capture or reload.
    if (pin_ev)
    begin
      if (c[tcr_pkg::CT_CPRL])
      begin
        nxt_st.rcap = st_ff.cnt;
        if (st_ff.mode[tcr_pkg::MD_CLR])
        begin
          nxt_st.cnt = 16'h0000;
        end
      end
      else if (!st_ff.mode[tcr_pkg::MD_DOWN_COUNT_ENABLE])
      begin
        nxt_st.cnt = st_ff.rcap;
      end
    end
    nxt_st.baud_tick = ovf && baud;
    // Register writes in the data phase; set by hardware wins below.
    if (st_ff.req.act && st_ff.req.wr)
    begin
      unique case (st_ff.req.addr)
        tcr_pkg::CTRL_ADDR: nxt_st.ctrl = wd;
        tcr_pkg::MODE_ADDR: nxt_st.mode = wd & tcr_pkg::MODE_MASK;
        tcr_pkg::RCL_ADDR: nxt_st.rcap[7:0] = wd;
        tcr_pkg::RCH_ADDR: nxt_st.rcap[15:8] = wd;
        tcr_pkg::CNTL_ADDR: nxt_st.cnt[7:0] = wd;
        tcr_pkg::CNTH_ADDR: nxt_st.cnt[15:8] = wd;
        default: nxt_st.ctrl = nxt_st.ctrl;
      endcase
    end
    // Clock out follows the enable after this cycle's write, so it drops with the pin enable.
    if (!nxt_st.mode[tcr_pkg::MD_OE])
    begin
      nxt_st.clk_out = 1'b0;
    end
    else if (ovf)
    begin
      nxt_st.clk_out = !st_ff.clk_out;
    end
    if (ovf && !baud)
    begin
      nxt_st.ctrl[tcr_pkg::CT_OVF] = 1'b1;
    end
    // External flag: set by pin edge, or by overflow in down-count mode.
    if (pin_ev || (ovf && dn) || (ovf && st_ff.mode[tcr_pkg::MD_DOWN_COUNT_ENABLE] && !baud
      && !c[tcr_pkg::CT_CPRL]))
    begin
      nxt_st.ctrl[tcr_pkg::CT_EXF] = 1'b1;
    end
    // Interrupt follows both flags when enabled.
    nxt_st.irq = int_enable_in && (nxt_st.ctrl[tcr_pkg::CT_OVF]
      || nxt_st.ctrl[tcr_pkg::CT_EXF]);
    // Read data is taken after this cycle's writes, so a read right behind a write sees it.
    if (nxt_st.req.act && !hwrite_in)
    begin
      nxt_st.rdata = {24'h000000, rd_reg(nxt_st, haddr_in[9:0])};
    end
  end

  // Registers the whole state.
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_ff <= '0;
      oe_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      oe_ff <= nxt_st.mode[tcr_pkg::MD_OE];
    end
  end

  // Outputs come straight from flip-flops; ready and response are tied constants.
  assign hrdata_out = st_ff.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign clk_out_out = st_ff.clk_out;
  assign clk_out_oe_out = oe_ff;
  assign baud_tick_out = st_ff.baud_tick;
  assign rx_baud_sel_out = st_ff.ctrl[tcr_pkg::CT_RCLK];
  assign tx_baud_sel_out = st_ff.ctrl[tcr_pkg::CT_TCLK];
  assign irq_out = st_ff.irq;
endmodule : tcr_timer

/* File: bench/tcr_pins.sv */
// Model of the external count and capture pins that sit outside the timer.
`timescale 1ns/1ps
module tcr_pins (
  input wire logic clk_sys_in, // System clock.
  output logic count_input_pin_out, // Count pin, idles high.
  output logic ext_capture_pin_out // Capture pin, idles high.
);
  initial count_input_pin_out = 1'b1;
  initial ext_capture_pin_out = 1'b1;
  // One falling edge; the low level is held two clocks and the high level four, so sampling cannot miss it.
  task automatic fall(input bit cap);
    @(posedge clk_sys_in);
    if (cap)
      ext_capture_pin_out <= 1'b0;
    else
      count_input_pin_out <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    ext_capture_pin_out <= 1'b1;
    count_input_pin_out <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
  endtask : fall
  // Holds the capture pin at a level, which picks the count direction in down-count mode.
  task automatic hold(input bit lvl);
    @(posedge clk_sys_in);
    ext_capture_pin_out <= lvl;
  endtask : hold
endmodule : tcr_pins

/* File: bench/tcr_chk.sv */
// Checker of port relations of the timer, bound to its top module.
`timescale 1ns/1ps
module tcr_chk (
  input wire logic clk_sys_in, rstn_in, hsel_in, hwrite_in, hready_in, int_enable_in, // Inputs.
  input wire logic [31:0] haddr_in, hwdata_in, hrdata_out, // Bus words.
  input wire logic [1:0] htrans_in, // Transfer type.
  input wire logic [2:0] hsize_in, // Transfer size.
  input wire logic timebase_select_in, count_input_pin_in, ext_capture_pin_in, // Pins.
  input wire logic hreadyout_out, hresp_out, clk_out_out, clk_out_oe_out, // Outputs.
  input wire logic baud_tick_out, rx_baud_sel_out, tx_baud_sel_out, irq_out // Outputs.
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // A baud tick is followed by one quiet cycle; clock out stays off two cycles.
  sequence quiet_s; ##1 !baud_tick_out; endsequence
  sequence off_s; !clk_out_oe_out ##1 !clk_out_oe_out; endsequence
  // Properties tie each output except tx_baud_sel_out and clk_out_oe_out to its cause.
  ready_okay_a: assert property (hreadyout_out && !hresp_out) else $error("bus answer bad");
  rdata_upper_a: assert property (hrdata_out[31:8] == 24'h0) else $error("upper read bits set");
  irq_enable_a: assert property (irq_out |-> $past(int_enable_in)) else $error("irq unmasked");
  tick_sel_a: assert property (baud_tick_out |-> $past(rx_baud_sel_out || tx_baud_sel_out))
    else $error("baud tick off mode");
  tick_gap_a: assert property (baud_tick_out |-> quiet_s) else $error("baud ticks too close");
  clk_off_a: assert property (off_s |-> !clk_out_out) else $error("clock out while off");
  clk_tog_a: assert property ($changed(clk_out_out) |-> clk_out_oe_out || $past(clk_out_oe_out))
    else $error("clock out moved while off");
  sel_write_a: assert property ($changed(rx_baud_sel_out) |->
    $past(hsel_in && hwrite_in && htrans_in == 2'h2, 2)) else $error("select moved alone");
endmodule : tcr_chk
bind tcr_timer tcr_chk tcr_chk_i (.*);

/* File: bench/tb.sv */
// Self-checking bench for the timer: registers, counting, capture, baud and interrupt.
`timescale 1ns/1ps
module tb;
  logic clk_sys_in = 1'b0, rstn_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, int_en = 1'b1;
  logic tbase = 1'b1, co;
  logic [1:0] htrans_in = 2'h0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, rd;
  wire logic [31:0] hrdata_out;
  wire logic hready, hresp, clk_out, clk_oe, tick, rx_sel, tx_sel, irq, cnt_pin, cap_pin;
  int fail_count = 0, num_checks = 0, n;
  always #20 clk_sys_in = ~clk_sys_in;
  tcr_pins tcr_pins_i (.clk_sys_in(clk_sys_in), .count_input_pin_out(cnt_pin),
    .ext_capture_pin_out(cap_pin));
  tcr_timer tcr_timer_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
    .hwdata_in(hwdata_in), .hready_in(hready), .timebase_select_in(tbase),
    .count_input_pin_in(cnt_pin), .ext_capture_pin_in(cap_pin), .int_enable_in(int_en),
    .hrdata_out(hrdata_out), .hreadyout_out(hready), .hresp_out(hresp), .clk_out_out(clk_out),
    .clk_out_oe_out(clk_oe), .baud_tick_out(tick), .rx_baud_sel_out(rx_sel),
    .tx_baud_sel_out(tx_sel), .irq_out(irq));
  // Compares and counts.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One single AHB-Lite transfer; read data lands in rd.
  task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys_in);
    hsel_in <= 1'b1;
    haddr_in <= {22'h0, a};
    hwrite_in <= w;
    htrans_in <= tcr_pkg::HTRANS_NONSEQ;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    rd = hrdata_out;
  endtask : bus
  task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : rchk
  // Byte pairs: low word then high word.
  task automatic set16(input logic [9:0] a, input logic [15:0] v);
    bus(a, 1'b1, {24'h0, v[7:0]});
    bus(a + 10'h4, 1'b1, {24'h0, v[15:8]});
  endtask : set16
  task automatic chk16(input logic [9:0] a, input logic [15:0] v);
    rchk(a, {24'h0, v[7:0]});
    rchk(a + 10'h4, {24'h0, v[15:8]});
  endtask : chk16
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    complete_run();
  end
  // Main sequence of tests.
  initial
  begin
    repeat (3) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(tcr_pkg::CTRL_ADDR + 10'(4 * i), 32'(i == 6));
    set16(tcr_pkg::RCL_ADDR, 16'hFFF0);
    chk16(tcr_pkg::RCL_ADDR, 16'hFFF0);
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'hFF);
    rchk(tcr_pkg::MODE_ADDR, {24'h0, tcr_pkg::MODE_MASK});
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'h0);
    $display("Test registers done");
    set16(tcr_pkg::CNTL_ADDR, 16'hFFFE);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h04);
    repeat (20) @(posedge clk_sys_in);
    rchk(tcr_pkg::CTRL_ADDR, 32'h84);
    check(32'(irq), 32'h1);
    rchk(tcr_pkg::CNTH_ADDR, 32'hFF);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h0);
    bus(tcr_pkg::CNTL_ADDR, 1'b0, 32'h0);
    n = rd;
    repeat (10) @(posedge clk_sys_in);
    rchk(tcr_pkg::CNTL_ADDR, 32'(n));
    check(32'(irq), 32'h0);
    $display("Test overflow done");
    set16(tcr_pkg::CNTL_ADDR, 16'h0);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h06);
    repeat (3) tcr_pins_i.fall(1'b0);
    rchk(tcr_pkg::CNTL_ADDR, 32'h3);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h0);
    $display("Test counter done");
    set16(tcr_pkg::CNTL_ADDR, 16'h1234);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h09);
    tcr_pins_i.fall(1'b1);
    chk16(tcr_pkg::RCL_ADDR, 16'h1234);
    rchk(tcr_pkg::CTRL_ADDR, 32'h49);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h09);
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'h08);
    tcr_pins_i.fall(1'b1);
    chk16(tcr_pkg::CNTL_ADDR, 16'h0);
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'h0);
    bus(tcr_pkg::CNTL_ADDR, 1'b1, 32'h55);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h01);
    tcr_pins_i.fall(1'b1);
    rchk(tcr_pkg::RCL_ADDR, 32'h34);
    rchk(tcr_pkg::CTRL_ADDR, 32'h01);
    $display("Test capture done");
    set16(tcr_pkg::RCL_ADDR, 16'hFFFE);
    set16(tcr_pkg::CNTL_ADDR, 16'hFFFE);
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'h02);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h34);
    do @(posedge clk_sys_in); while (tick !== 1'b1);
    co = clk_out;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (tick !== 1'b1);
    check(32'(n), 32'(2 * tcr_pkg::BAUD_DIV));
    check(32'(clk_out), 32'(!co));
    rchk(tcr_pkg::CTRL_ADDR, 32'h34);
    check({29'h0, rx_sel, tx_sel, clk_oe}, 32'h7);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h0);
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'h0);
    $display("Test baud done");
    // Reload of all ones overflows on every tick, so clock out shows the tick period.
    set16(tcr_pkg::RCL_ADDR, 16'hFFFF);
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'h02);
    for (int s = 0; s < 2; s++)
    begin
      tbase <= s[0];
      bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h04);
      @(posedge clk_sys_in);
      co = clk_out;
      do @(posedge clk_sys_in); while (clk_out === co);
      co = clk_out;
      n = 0;
      do
      begin
        @(posedge clk_sys_in);
        n++;
      end
      while (clk_out === co);
      check(32'(n), (s == 0) ? 32'(tcr_pkg::SLOW_DIV) : 32'(tcr_pkg::FAST_DIV));
      bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h0);
    end
    $display("Test timebase done");
    // Down count from 0x0012 to the reload value wraps to all ones and sets both flags.
    set16(tcr_pkg::RCL_ADDR, 16'h0010);
    set16(tcr_pkg::CNTL_ADDR, 16'h0012);
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'h01);
    tcr_pins_i.hold(1'b0);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h04);
    repeat (20) @(posedge clk_sys_in);
    rchk(tcr_pkg::CNTH_ADDR, 32'hFF);
    rchk(tcr_pkg::CTRL_ADDR, 32'hC4);
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h0);
    bus(tcr_pkg::MODE_ADDR, 1'b1, 32'h0);
    tcr_pins_i.hold(1'b1);
    $display("Test down count done");
    bus(tcr_pkg::CTRL_ADDR, 1'b1, 32'h40);
    repeat (2) @(posedge clk_sys_in);
    check({30'h0, irq, clk_oe}, 32'h2);
    int_en <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    check(32'(irq), 32'h0);
    $display("Test interrupt done");
    complete_run();
  end
endmodule : tb
